// *** src/pwm_fault_pkg.sv ***
// Register indexes, field positions and reset values of the fault block
package pwm_fault_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IX_CTRL_L = 14'h0040;
  localparam logic [13:0] IX_CTRL_H = 14'h0041;
  localparam logic [13:0] IX_FAULT_CONTROL_L = 14'h0042;
  localparam logic [13:0] IX_FAULT_CONTROL_H = 14'h0043;
  localparam logic [13:0] IX_FACK_L = 14'h0044;
  localparam logic [13:0] IX_FSTAT_H = 14'h0045;
  localparam logic [13:0] IX_OUT_L = 14'h0046;
  localparam logic [13:0] IX_OUT_H = 14'h0047;
  localparam logic [13:0] IX_CNT_L = 14'h0048;
  localparam logic [13:0] IX_CNT_H = 14'h0049;
  localparam logic [13:0] IX_CMOD_L = 14'h004a;
  localparam logic [13:0] IX_CMOD_H = 14'h004b;
  localparam logic [13:0] IX_VAL0_L = 14'h004c;
  localparam logic [13:0] IX_VAL0_H = 14'h004d;
  localparam logic [13:0] IX_VAL1_L = 14'h004e;
  localparam logic [13:0] IX_VAL1_H = 14'h004f;
  localparam logic [13:0] IX_VAL2_L = 14'h0050;
  localparam logic [13:0] IX_VAL2_H = 14'h0051;
  localparam logic [13:0] IX_VAL3_L = 14'h0052;
  localparam logic [13:0] IX_VAL3_H = 14'h0053;
  localparam logic [13:0] IX_VAL4_L = 14'h0054;
  localparam logic [13:0] IX_VAL4_H = 14'h0055;
  localparam logic [13:0] IX_VAL5_L = 14'h0056;
  localparam logic [13:0] IX_VAL5_H = 14'h0057;
  localparam logic [13:0] IX_DTIM0_L = 14'h0058;
  localparam logic [13:0] IX_DTIM0_H = 14'h0059;
  localparam logic [13:0] IX_DTIM1_L = 14'h005a;
  localparam logic [13:0] IX_DTIM1_H = 14'h005b;
  localparam logic [13:0] IX_DMAP1_L = 14'h005c;
  localparam logic [13:0] IX_DMAP1_H = 14'h005d;
  localparam logic [13:0] IX_DMAP2_L = 14'h005e;
  localparam logic [13:0] IX_CNFG_L = 14'h1820;
  localparam logic [13:0] IX_CNFG_H = 14'h1821;
  localparam logic [13:0] IX_CCTRL_L = 14'h1822;
  localparam logic [13:0] IX_CCTRL_H = 14'h1823;
  localparam logic [13:0] IX_PECTRL_L = 14'h1826;
  localparam logic [13:0] IX_CINV_H = 14'h1829;

  // ----------------------------------------------------------------
  // Storage slots
  // ----------------------------------------------------------------
  localparam int NUM_SLOTS = 37;
  localparam int SLOT_W = 6;
  localparam int SLOT_CNFG_L = 31;
  localparam int SLOT_CNFG_H = 32;
  localparam int SLOT_CCTRL_L = 33;
  localparam int SLOT_CCTRL_H = 34;
  localparam int SLOT_PECTRL_L = 35;
  localparam int SLOT_CINV_H = 36;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DTIM_L = 8'hff;
  localparam logic [7:0] RST_DTIM_H = 8'h0f;
  localparam logic [7:0] RST_DMAP = 8'hff;
  localparam logic [7:0] RST_CCTRL_H = 8'h40;
  localparam logic [7:0] RST_PECTRL_L = 8'h03;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLOCK_PRESCALE_LSB = 6;
  localparam int CLOCK_PRESCALE_W = 2;
  localparam int FC_MODE_LSB = 0;
  localparam int FC_IE_LSB = 4;
  localparam int FC_POL_LSB = 0;
  localparam int FS_FLAG_LSB = 0;
  localparam int FS_PIN_LSB = 4;
  localparam int MAP_BANK = 4;
  localparam int FILTER_SAMPLES = 2;

endpackage : pwm_fault_pkg

// *** src/op_clock_divider.sv ***
// Operation clock enable: bus clock divided by 1, 2, 4 or 8
`timescale 1ns/1ps
`default_nettype none
module op_clock_divider
  import pwm_fault_pkg::*;
#(
  parameter int SEL_W = CLOCK_PRESCALE_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [SEL_W-1:0] prescale,
  output logic tick
);

  typedef struct packed {
    logic [(1<<SEL_W)-2:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;
  logic [(1<<SEL_W)-2:0] mask;

  if (SEL_W < 1 || SEL_W > 3) begin : g_chk
    $error("op_clock_divider: unsupported select width");
  end

  always_comb begin
    s_d = s_q;
    mask = '1 >> (((1 << SEL_W) - 1) - int'(prescale));
    s_d.cnt = s_q.cnt + 1'b1;
    s_d.tick = ((s_q.cnt & mask) == mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : op_clock_divider
`default_nettype wire

// *** src/fault_filter.sv ***
// Fault input filter: level changes only after repeated equal samples
`timescale 1ns/1ps
`default_nettype none
module fault_filter
  import pwm_fault_pkg::*;
#(
  parameter int SAMPLES = FILTER_SAMPLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic asserted,
  output logic pin_state,
  output logic rise
);

  localparam int RUN_W = $clog2(SAMPLES + 1);

  typedef struct packed {
    logic [RUN_W-1:0] run;
    logic pin;
    logic rise;
  } filt_state_t;

  filt_state_t s_q;
  filt_state_t s_d;

  if (SAMPLES < 1) begin : g_chk
    $error("fault_filter: sample count must be at least one");
  end

  always_comb begin
    s_d = s_q;
    s_d.rise = 1'b0;
    if (tick) begin
      if (asserted != s_q.pin) begin
        if (int'(s_q.run) + 1 >= SAMPLES) begin
          s_d.pin = asserted;
          s_d.rise = asserted;
          s_d.run = '0;
        end else begin
          s_d.run = s_q.run + 1'b1;
        end
      end else begin
        s_d.run = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_state = s_q.pin;
  assign rise = s_q.rise;

endmodule : fault_filter
`default_nettype wire

// *** src/pwm_fault_protection.sv ***
// Fault protection of the six-output modulator with its register file
//
// Contract
// - Per-input polarity selects which level is fault
// - Fault gates only pins, generator keeps running
// - One four-bit map bank per output pin
// - Fault detection works while generator disabled
// - Two equal fault samples set flag, pin
// - Pin state clears after two clean samples
// - Writing one to acknowledge clears fault flag
// - Enabled flag latches interrupt until ack, disable
// - Auto mode re-enables at boundary once clean
// - Auto mode ignores acknowledge for pin disable
// - Manual inputs 0,2: ack re-enables at boundary
// - Manual inputs 0,2: new fault needs re-edge
// - Manual inputs 1,3: ack and clean sample
// - Boundary at cycle start and counter at or above modulus
// - Fault disable overrides software output control
// - Clear every tick when off, boundaries when on
// - Disable map resets to all ones
// - Deadtime resets low ff, high 0f
// - Operation clock divides bus clock by 1-8
`timescale 1ns/1ps
`default_nettype none
module pwm_fault_protection
  import pwm_fault_pkg::*;
#(
  parameter int NF = 4,
  parameter int NO = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NF-1:0] fault_input,
  output logic [NO-1:0] pwm_pin,
  output logic [NO-1:0] pin_disabled,
  output logic fault_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_SLOTS-1:0][7:0] regs;
    logic [NF-1:0] sync1;
    logic [NF-1:0] sync2;
    logic [NF-1:0] flag;
    logic [NF-1:0] irq;
    logic [NF-1:0] dis;
    logic [15:0] cnt;
    logic rdy;
    logic err;
    logic irq_out;
    logic [31:0] rdata;
    logic [NO-1:0] pins;
    logic [NO-1:0] off;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  if (NF < 1 || NF > MAP_BANK || NO != 6) begin : g_chk
    $error("pwm_fault_protection: unsupported input or output count");
  end

  // ----------------------------------------------------------------
  // Reset image of the register file
  // ----------------------------------------------------------------
  function automatic top_state_t reset_state();
    top_state_t r;
    r = '0;
    r.regs[int'(IX_DTIM0_L - IX_CTRL_L)] = RST_DTIM_L;
    r.regs[int'(IX_DTIM0_H - IX_CTRL_L)] = RST_DTIM_H;
    r.regs[int'(IX_DTIM1_L - IX_CTRL_L)] = RST_DTIM_L;
    r.regs[int'(IX_DTIM1_H - IX_CTRL_L)] = RST_DTIM_H;
    r.regs[int'(IX_DMAP1_L - IX_CTRL_L)] = RST_DMAP;
    r.regs[int'(IX_DMAP1_H - IX_CTRL_L)] = RST_DMAP;
    r.regs[int'(IX_DMAP2_L - IX_CTRL_L)] = RST_DMAP;
    r.regs[SLOT_CCTRL_H] = RST_CCTRL_H;
    r.regs[SLOT_PECTRL_L] = RST_PECTRL_L;
    return r;
  endfunction : reset_state

  localparam top_state_t RESET_STATE = reset_state();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [13:0] ix;
  logic hit;
  logic [SLOT_W-1:0] slot;
  logic writable;

  assign ix = paddr[15:2];

  always_comb begin
    hit = 1'b0;
    slot = '0;
    // Misaligned addresses match nothing and are refused
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (ix >= IX_CTRL_L && ix <= IX_DMAP2_L) begin
      hit = 1'b1;
      slot = SLOT_W'(ix - IX_CTRL_L);
    end else if (ix == IX_CNFG_L) begin
      hit = 1'b1;
      slot = SLOT_W'(SLOT_CNFG_L);
    end else if (ix == IX_CNFG_H) begin
      hit = 1'b1;
      slot = SLOT_W'(SLOT_CNFG_H);
    end else if (ix == IX_CCTRL_L) begin
      hit = 1'b1;
      slot = SLOT_W'(SLOT_CCTRL_L);
    end else if (ix == IX_CCTRL_H) begin
      hit = 1'b1;
      slot = SLOT_W'(SLOT_CCTRL_H);
    end else if (ix == IX_PECTRL_L) begin
      hit = 1'b1;
      slot = SLOT_W'(SLOT_PECTRL_L);
    end else if (ix == IX_CINV_H) begin
      hit = 1'b1;
      slot = SLOT_W'(SLOT_CINV_H);
    end
  end

  // Status and counter bytes are read only; acknowledge is a strobe
  assign writable = hit
    && ix != IX_FACK_L
    && ix != IX_FSTAT_H
    && ix != IX_CNT_L
    && ix != IX_CNT_H;

  // ----------------------------------------------------------------
  // Register fields
  // ----------------------------------------------------------------
  logic gen_en;
  logic [CLOCK_PRESCALE_W-1:0] clock_prescale;
  logic [NF-1:0] clr_mode;
  logic [NF-1:0] irq_en;
  logic [NF-1:0] pol;
  logic [NO-1:0] sw_lvl;
  logic [NO-1:0] sw_en;
  logic [15:0] modulus;
  logic [NO*MAP_BANK-1:0] dmap;
  logic [NO-1:0][15:0] value;

  localparam int S_CTRL_L = int'(IX_CTRL_L - IX_CTRL_L);
  localparam int S_FAULT_CONTROL_L = int'(IX_FAULT_CONTROL_L - IX_CTRL_L);
  localparam int S_FAULT_CONTROL_H = int'(IX_FAULT_CONTROL_H - IX_CTRL_L);
  localparam int S_OUT_L = int'(IX_OUT_L - IX_CTRL_L);
  localparam int S_OUT_H = int'(IX_OUT_H - IX_CTRL_L);
  localparam int S_CMOD_L = int'(IX_CMOD_L - IX_CTRL_L);
  localparam int S_CMOD_H = int'(IX_CMOD_H - IX_CTRL_L);
  localparam int S_VAL0_L = int'(IX_VAL0_L - IX_CTRL_L);
  localparam int S_DMAP1_L = int'(IX_DMAP1_L - IX_CTRL_L);
  localparam int S_DMAP1_H = int'(IX_DMAP1_H - IX_CTRL_L);
  localparam int S_DMAP2_L = int'(IX_DMAP2_L - IX_CTRL_L);

  assign gen_en = s_q.regs[S_CTRL_L][CTRL_EN_BIT];
  assign clock_prescale = s_q.regs[S_CTRL_L][CTRL_CLOCK_PRESCALE_LSB +: CLOCK_PRESCALE_W];
  assign clr_mode = s_q.regs[S_FAULT_CONTROL_L][FC_MODE_LSB +: NF];
  assign irq_en = s_q.regs[S_FAULT_CONTROL_L][FC_IE_LSB +: NF];
  assign pol = s_q.regs[S_FAULT_CONTROL_H][FC_POL_LSB +: NF];
  assign sw_lvl = s_q.regs[S_OUT_L][NO-1:0];
  assign sw_en = s_q.regs[S_OUT_H][NO-1:0];
  assign modulus = {s_q.regs[S_CMOD_H], s_q.regs[S_CMOD_L]};
  assign dmap = {s_q.regs[S_DMAP2_L],
                 s_q.regs[S_DMAP1_H],
                 s_q.regs[S_DMAP1_L]};

  // Each value pair forms one 16-bit compare word
  for (genvar k = 0; k < NO; k++) begin : g_val
    assign value[k] = {s_q.regs[S_VAL0_L + 2*k + 1],
                       s_q.regs[S_VAL0_L + 2*k]};
  end

  // ----------------------------------------------------------------
  // Operation clock and fault filters
  // ----------------------------------------------------------------
  logic tick;
  logic [NF-1:0] pin_state;
  logic [NF-1:0] rise;

  op_clock_divider #(
    .SEL_W(CLOCK_PRESCALE_W)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .prescale(clock_prescale),
    .tick(tick)
  );

  for (genvar i = 0; i < NF; i++) begin : g_filt
    fault_filter #(
      .SAMPLES(FILTER_SAMPLES)
    ) u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .asserted(s_q.sync2[i] ~^ pol[i]),
      .pin_state(pin_state[i]),
      .rise(rise[i])
    );
  end

  // ----------------------------------------------------------------
  // Counter boundaries and fault clearing events
  // ----------------------------------------------------------------
  logic boundary;
  logic clr_evt;
  logic [NF-1:0] ack;
  logic acc;
  logic prep;
  logic wr_en;

  assign acc = psel && penable && s_q.rdy;
  assign prep = psel && penable && !s_q.rdy;
  assign wr_en = acc && pwrite && writable && pstrb[0];
  // Edge-aligned only: cycle start and modulus match coincide
  assign boundary = gen_en && tick && (s_q.cnt >= modulus);
  assign clr_evt = gen_en ? boundary : tick;
  assign ack = (acc && pwrite && pstrb[0] && ix == IX_FACK_L
                && paddr[1:0] == 2'b00) ? pwdata[NF-1:0] : '0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic can_clr;
    logic lvl;
    logic pulse;
    logic [7:0] rd_byte;
    can_clr = 1'b0;
    lvl = 1'b0;
    pulse = 1'b0;
    rd_byte = '0;
    s_d = s_q;

    // Fault inputs come from pins
    // Only the second stage feeds any logic
    s_d.sync1 = fault_input;
    s_d.sync2 = s_q.sync1;

    // Counter runs only while the generator is enabled
    if (!gen_en) begin
      s_d.cnt = '0;
    end else if (tick) begin
      if (s_q.cnt >= modulus) begin
        s_d.cnt = 16'h0001;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end

    // Per-input flag, interrupt latch and disable latch
    // Set wins over acknowledge and over a clear event
    for (int i = 0; i < NF; i++) begin
      s_d.flag[i] = rise[i] | (s_q.flag[i] & ~ack[i]);
      s_d.irq[i] = irq_en[i]
        & (rise[i] | (s_q.irq[i] & ~ack[i]));
      // Manual even inputs clear on ack alone, odd ones need a clean pin
      if (clr_mode[i]) begin
        can_clr = ~pin_state[i];
      end else if ((i % 2) == 0) begin
        can_clr = ~s_q.flag[i];
      end else begin
        can_clr = ~s_q.flag[i] & ~pin_state[i];
      end
      s_d.dis[i] = rise[i]
        | (s_q.dis[i] & ~(clr_evt & can_clr));
    end
    s_d.irq_out = |s_d.irq;

    // Output pins: generator or software level, gated by faults
    for (int k = 0; k < NO; k++) begin
      s_d.off[k] = |(dmap[k*MAP_BANK +: NF] & s_q.dis);
      pulse = gen_en && s_q.cnt != 16'h0000 && s_q.cnt <= value[k];
      lvl = sw_en[k] ? sw_lvl[k] : pulse;
      s_d.pins[k] = lvl & ~s_d.off[k];
    end

    // Bus access: one wait state, answer registered
    s_d.rdy = prep;
    if (prep) begin
      s_d.err = ~hit;
      if (ix == IX_FSTAT_H) begin
        rd_byte[FS_FLAG_LSB +: NF] = s_q.flag;
        rd_byte[FS_PIN_LSB +: NF] = pin_state;
      end else if (ix == IX_CNT_L) begin
        rd_byte = s_q.cnt[7:0];
      end else if (ix == IX_CNT_H) begin
        rd_byte = s_q.cnt[15:8];
      end else if (ix == IX_FACK_L || !hit) begin
        rd_byte = '0;
      end else begin
        rd_byte = s_q.regs[slot];
      end
      // Writes leave the last read data standing
      if (!pwrite) begin
        s_d.rdata = {24'h000000, rd_byte};
      end
    end else if (acc) begin
      s_d.err = 1'b0;
    end
    if (wr_en) begin
      s_d.regs[slot] = pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  assign prdata = s_q.rdata;
  assign pready = s_q.rdy;
  assign pslverr = s_q.err;
  assign pwm_pin = s_q.pins;
  assign pin_disabled = s_q.off;
  assign fault_irq = s_q.irq_out;

endmodule : pwm_fault_protection
`default_nettype wire

// *** tb/fault_source_model.sv ***
// Fault source model: steady level per input, optional chatter
`timescale 1ns/1ps
`default_nettype none
module fault_source_model (
  input wire logic pclk,
  input wire logic [3:0] level,
  input wire logic [3:0] chatter,
  output logic [3:0] fault_input
);
  logic flip_q = 1'b0;
  logic [3:0] out_q = 4'hf;
  // Pins change just after a rising edge; chatter flips every cycle
  always @(posedge pclk) begin
    flip_q <= ~flip_q;
    out_q <= level ^ (chatter & {4{flip_q}});
  end
  assign fault_input = out_q;
endmodule : fault_source_model
`default_nettype wire

// *** tb/pwm_fault_protection_monitor.sv ***
// Assertions on the ports of the fault protection block
`timescale 1ns/1ps
`default_nettype none
module pwm_fault_protection_monitor
  import pwm_fault_pkg::*;
#(
  parameter int NF = 4,
  parameter int NO = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NF-1:0] fault_input,
  input wire logic [NO-1:0] pwm_pin,
  input wire logic [NO-1:0] pin_disabled,
  input wire logic fault_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_one_wait;
    psel && $rose(penable) |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("no answer after one wait cycle");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held longer than one cycle");
  property p_ready_cause;
    pready |-> psel && penable && $past(penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready outside an access phase");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error flag without ready");
  property p_misalign;
    pready && paddr[1:0] != 2'b00 |-> pslverr;
  endproperty
  a_misalign: assert property (p_misalign)
    else $error("misaligned access not refused");
  property p_err_read;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_err_read: assert property (p_err_read)
    else $error("refused read returned data");
  property p_rdata_hold;
    $changed(prdata) |-> pready && !pwrite && prdata[31:8] == 24'h0;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed outside a read answer");
  property p_pin_gate;
    (pwm_pin & pin_disabled) == '0;
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("disabled pin driven active");
  property p_irq_off;
    pready && pwrite && pstrb[0] && paddr == {IX_FAULT_CONTROL_L, 2'b00}
      && pwdata[7:4] == 4'h0 |-> ##[1:3] !fault_irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("request stayed after enables cleared");
  c_refused: cover property (pready && pslverr);
  c_disable: cover property ($rose(|pin_disabled));
  c_enable: cover property ($fell(|pin_disabled));
  c_irq: cover property ($rose(fault_irq));
endmodule : pwm_fault_protection_monitor
bind pwm_fault_protection pwm_fault_protection_monitor #(.NF(NF), .NO(NO))
  mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fault_input(fault_input), .pwm_pin(pwm_pin),
  .pin_disabled(pin_disabled), .fault_irq(fault_irq));
`default_nettype wire

// *** tb/pwm_fault_protection_tb_top.sv ***
// Self-checking bench for the fault protection block
`timescale 1ns/1ps
`default_nettype none
module pwm_fault_protection_tb_top;
  import pwm_fault_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, lvl, chat, fi, pol, mode;
  logic [5:0] pin, dis, ex;
  logic [23:0] map;
  logic [31:0] seed = 32'ha5be3398;
  int n_errors = 0;
  int n_checks = 0;
  int k, n;
  localparam logic [13:0] RIX [9] = '{IX_DTIM0_L, IX_DTIM0_H, IX_DTIM1_L,
    IX_DTIM1_H, IX_DMAP1_L, IX_DMAP1_H, IX_DMAP2_L, IX_CCTRL_H, IX_PECTRL_L};
  localparam logic [7:0] RVAL [9] = '{8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff,
    8'hff, 8'hff, 8'h40, 8'h03};
  pwm_fault_protection dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_input(fi), .pwm_pin(pin), .pin_disabled(dis), .fault_irq(irq));
  fault_source_model src (.pclk(pclk), .level(lvl), .chatter(chat),
    .fault_input(fi));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [5:0] exp_dis(logic [23:0] m, logic [3:0] act);
    logic [5:0] r;
    for (int j = 0; j < 6; j++) r[j] = |(m[4*j +: 4] & act);
    return r;
  endfunction : exp_dis
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(string what, logic [31:0] e, logic [31:0] got);
    n_checks++;
    if (got !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask : chk
  task automatic apb(logic w, logic [13:0] ix, logic [7:0] d,
                     logic [1:0] lo = 2'b00);
    int t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, lo};
    pwdata <= (rnd() << 8) | 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is looked at mid-cycle, where it has settled
    do begin
      @(negedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    er = pslverr;
    if (t >= 20) begin
      n_errors++;
      stop_test();
    end
    // The transfer completes at the rising edge that sees pready high
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(logic [13:0] ix, logic [7:0] d);
    apb(1'b1, ix, d);
  endtask : wr
  task automatic rdc(logic [13:0] ix, logic [7:0] e);
    apb(1'b0, ix, 8'h00);
    chk("register", 32'(e), rd);
  endtask : rdc
  task automatic wt(int c);
    repeat (c) @(negedge pclk);
  endtask : wt
  task automatic lat_to(logic [5:0] want, output int c);
    c = 0;
    while (dis !== want && c < 200) begin
      @(negedge pclk);
      c++;
    end
  endtask : lat_to
  task automatic setup();
    wr(IX_FAULT_CONTROL_H, 8'(pol));
    @(posedge pclk);
    lvl <= ~pol;
    wr(IX_FAULT_CONTROL_L, {4'hf, mode});
    wr(IX_DMAP1_L, map[7:0]);
    wr(IX_DMAP1_H, map[15:8]);
    wr(IX_DMAP2_L, map[23:16]);
    wt(6);
    wr(IX_FACK_L, 8'h0f);
    wt(6);
    chk("idle", 0, dis);
  endtask : setup
  initial begin
    #(100 * 20000);
    n_errors++;
    stop_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    lvl = 4'hf;
    chat = 4'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (RIX[i]) rdc(RIX[i], RVAL[i]);
    apb(1'b1, IX_FAULT_CONTROL_H, 8'hff, 2'b10);
    chk("misaligned", 1, er);
    apb(1'b0, 14'h0060, 8'h00);
    chk("unmapped", 1, er);
    wr(IX_FSTAT_H, 8'hff);
    rdc(IX_FSTAT_H, 8'h00);
    wr(IX_OUT_L, 8'h3f);
    wr(IX_OUT_H, 8'h3f);
    for (int i = 0; i < 8; i++) begin
      k = i % 4;
      pol = 4'(rnd());
      mode = 4'(rnd());
      map = 24'(rnd()) | (24'h1 << (5 * k));
      ex = exp_dis(map, 4'h1 << k);
      setup();
      chat[k] <= 1'b1;
      wt(12);
      chat[k] <= 1'b0;
      wt(6);
      chk("chatter", 0, dis);
      lvl[k] <= pol[k];
      wt(8);
      chk("disable", ex, dis);
      chk("pins", ex ^ 6'h3f, pin);
      chk("irq", 1, irq);
      wr(IX_FACK_L, ~(8'h1 << k) & 8'h0f);
      rdc(IX_FSTAT_H, 8'h11 << k);
      wr(IX_FACK_L, 8'h1 << k);
      wt(4);
      chk("irq ack", 0, irq);
      chk("ack", (mode[k] | k[0]) ? ex : 6'h0, dis);
      chat[k] <= 1'b1;
      wt(10);
      chat[k] <= 1'b0;
      wt(4);
      rdc(IX_FSTAT_H, 8'h10 << k);
      chk("no refault", (mode[k] | k[0]) ? ex : 6'h0, dis);
      lvl[k] <= ~pol[k];
      wt(8);
      chk("release", 0, dis);
      lvl[k] <= pol[k];
      wt(8);
      chk("refault", ex, dis);
      lvl[k] <= ~pol[k];
      wr(IX_FACK_L, 8'h0f);
      wt(6);
    end
    wr(IX_DMAP1_L, 8'hff);
    wr(IX_DMAP1_H, 8'hff);
    wr(IX_DMAP2_L, 8'hff);
    for (int p = 0; p < 4; p++) begin
      wr(IX_CTRL_L, 8'(p << 6));
      @(posedge pclk);
      lvl[0] <= pol[0];
      lat_to(6'h3f, n);
      chk("delay", 1, n >= (1 << p) + 3 && n <= (2 << p) + 6);
      lvl[0] <= ~pol[0];
      wt(30);
      wr(IX_FACK_L, 8'h0f);
      wt(30);
    end
    wr(IX_CTRL_L, 8'h00);
    wr(IX_FAULT_CONTROL_L, 8'hf0);
    wr(IX_CMOD_L, 8'h20);
    @(posedge pclk);
    lvl[0] <= pol[0];
    wt(8);
    wr(IX_CTRL_L, 8'h01);
    apb(1'b0, IX_CNT_L, 8'h00);
    chk("counter", 1, rd != 0);
    wr(IX_FACK_L, 8'h01);
    lat_to(6'h00, n);
    chk("boundary", 1, n >= 20 && n <= 40);
    lvl[0] <= ~pol[0];
    wt(8);
    lvl[0] <= pol[0];
    wt(8);
    chk("irq on", 1, irq);
    wr(IX_FAULT_CONTROL_L, 8'h00);
    wt(3);
    chk("irq off", 0, irq);
    stop_test();
  end
endmodule : pwm_fault_protection_tb_top
`default_nettype wire
